// file: verilog/eeprom_cmd_pkg.sv
// Purpose: shared constants and types for the config eeprom command logic
// Assumes: byte-wide register accesses from both sides, one clock
// Notes: the serial eeprom engine sits outside and answers op requests
package eeprom_cmd_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_ASSIGN = 16'h0500;
    localparam logic [15:0] ADDR_HOST_ACC = 16'h0501;
    localparam logic [15:0] ADDR_CS_LO = 16'h0502;
    localparam logic [15:0] ADDR_CS_HI = 16'h0503;
    localparam logic [15:0] ADDR_WADDR = 16'h0504;
    localparam logic [15:0] ADDR_WADDR_LAST = 16'h0507;
    localparam logic [15:0] ADDR_DATA = 16'h0508;
    localparam logic [15:0] ADDR_DATA_LAST = 16'h050f;

    // command codes in control/status bits 10:8
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h1;
    localparam logic [2:0] CMD_WRITE = 3'h2;
    localparam logic [2:0] CMD_RELOAD = 3'h4;

    // control/status layout
    localparam int CS_WREN = 0;
    localparam int CS_RDSIZE = 6;
    localparam int CS_CMD_LO = 8;
    localparam int CS_ERR_CRC = 11;
    localparam int CS_ERR_DEV = 12;
    localparam int CS_ERR_ACK = 13;
    localparam int CS_ERR_WE = 14;
    localparam int CS_BUSY = 15;
    localparam int ASSIGN_HOST = 0;
    localparam int ASSIGN_FORCE = 1;
    localparam int HOST_ACC_BIT = 0;

    // this build reads four words per read command
    localparam logic READ_SIZE_4W = 1'b1;

    // configuration area
    localparam logic [31:0] LOAD_ADDR_LO = 32'h0000_0000;
    localparam logic [31:0] LOAD_ADDR_HI = 32'h0000_0004;
    localparam logic [15:0] CHK_DISABLE = 16'h88a4;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam int CRC_BYTES = 14;
    // word 0 bits that hold the link detection settings, kept on reload
    localparam logic [15:0] LINK_KEEP_MASK = 16'hf200;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_acc_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] addr;
        logic [15:0] wdata;
    } eep_op_t;

    typedef struct packed {
        logic done;
        logic nack;
        logic [63:0] rdata;
    } eep_ans_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD_REQ = 3'h1,
        ST_CMD_WAIT = 3'h3,
        ST_LOAD_REQ = 3'h4,
        ST_LOAD_WAIT = 3'h5
    } ctl_state_t;

endpackage

// file: verilog/cfg_crc8.sv
// Purpose: checksum over configuration words 0 to 6
// Assumes: low byte of each word first, msb of each byte first
// Notes: purely combinational, 14 bytes in one cycle
`timescale 1ns/1ps
module cfg_crc8 (
    input wire logic [111:0] words_i,
    output logic [7:0] crc_o
);
    always_comb begin
        logic [7:0] c;
        logic [7:0] b;
        c = eeprom_cmd_pkg::CRC_INIT;
        b = 8'h00;
        for (int i = 0; i < eeprom_cmd_pkg::CRC_BYTES; i++) begin
            b = words_i[i*8 +: 8];
            for (int k = 7; k >= 0; k--) begin
                if (c[7] ^ b[k]) begin
                    c = {c[6:0], 1'b0} ^ eeprom_cmd_pkg::CRC_POLY;
                end else begin
                    c = {c[6:0], 1'b0};
                end
            end
        end
        crc_o = c;
    end
endmodule

// file: verilog/config_eeprom_command_logic.sv
// Purpose: eeprom command, status and ownership registers with config area load
// Assumes: master writes arrive within frames closed by m_eof_i/m_frame_ok_i
// Notes: the serial protocol engine is external and answers through ans_i
`timescale 1ns/1ps
// Notes on behaviour
// - master owns the eeprom only while assignment bit 0 and host access bit are zero.
// - after reset the network master side owns the eeprom interface.
// - three commands: one-word write, multi-word read, configuration reload.
// - command codes in bits 10:8: 001 read, 010 write, 100 reload.
// - master write enable counts only within its frame, cleared at frame end.
// - master write without write enable is refused and sets bit 14.
// - local host writes need no write enable.
// - master commands start after an error-free frame end; host commands at once.
// - busy bit 15 stays high while a command runs; owner waits for it.
// - writing 000 to the command field clears error bits 11, 13 and 14; bit 12 stays.
// - missing acknowledge or invalid command code sets bit 13.
// - checksum mismatch sets bit 11 and leaves configured registers unchanged.
// - after reset a failed configuration load is retried exactly once.
// - two failed loads set bit 12 and keep load-done low.
// - host operational and process memory stay blocked until a good load.
// - new values only on good load; reload keeps alias and link bits.
// - master writing 0x02 then 0x00 to assignment takes ownership back.
// - read leaves 4 words in data; bit 6 is fixed at 1 to tell so.
// - reload reads the configuration area again into the registers.
// - configuration words 0 to 7 are read automatically after reset.
// - checksum is crc8 x8+x2+x+1 init 0xff over words 0-6; 0x88a4 skips it.
module config_eeprom_command_logic (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire eeprom_cmd_pkg::reg_acc_t m_acc_i,
    input wire logic m_eof_i,
    input wire logic m_frame_ok_i,
    input wire eeprom_cmd_pkg::reg_acc_t h_acc_i,
    input wire eeprom_cmd_pkg::eep_ans_t ans_i,
    output logic [7:0] m_rdata_o,
    output logic [7:0] h_rdata_o,
    output eeprom_cmd_pkg::eep_op_t op_o,
    output logic owner_host_o,
    output logic [15:0] cfg_pdi_ctrl_o,
    output logic [15:0] cfg_pdi_conf_o,
    output logic [15:0] cfg_sync_pulse_o,
    output logic [15:0] cfg_ext_pdi_o,
    output logic [15:0] cfg_alias_o,
    output logic load_done_o,
    output logic host_operational_flag_o,
    output logic process_mem_en_o
);
    logic [1:0] assign_r, assign_nxt;
    logic host_acc_r, host_acc_nxt;
    logic owner_r, owner_nxt;
    logic wren_r, wren_nxt;
    logic [2:0] cmd_r, cmd_nxt;
    logic busy_r, busy_nxt;
    logic err_we_r, err_we_nxt;
    logic err_ack_r, err_ack_nxt;
    logic err_dev_r, err_dev_nxt;
    logic err_crc_r, err_crc_nxt;
    logic pend_r, pend_nxt;
    logic [31:0] waddr_r, waddr_nxt;
    logic [63:0] data_r, data_nxt;
    logic [63:0] ldbuf_r, ldbuf_nxt;
    logic [15:0] cfg_r [5];
    logic [15:0] cfg_nxt [5];
    logic reload_r, reload_nxt;
    logic attempt_r, attempt_nxt;
    logic half_r, half_nxt;
    logic load_done_r, load_done_nxt;
    logic [7:0] m_rdata_r, m_rdata_nxt;
    logic [7:0] h_rdata_r, h_rdata_nxt;
    eeprom_cmd_pkg::eep_op_t op_r, op_nxt;
    eeprom_cmd_pkg::ctl_state_t state_r, state_nxt;
    eeprom_cmd_pkg::reg_acc_t own_acc;
    logic [15:0] cs_word;
    logic [127:0] area;
    logic [7:0] crc_calc;
    logic crc_ok;

    cfg_crc8 u_crc (
        .words_i(area[111:0]),
        .crc_o(crc_calc)
    );

    // config area as seen when the second half answers
    assign area = {ans_i.rdata, ldbuf_r};
    assign crc_ok = (area[127:112] == eeprom_cmd_pkg::CHK_DISABLE) ||
                    (area[119:112] == crc_calc);

    assign cs_word = {busy_r, err_we_r, err_ack_r, err_dev_r, err_crc_r, cmd_r,
                      1'b0, eeprom_cmd_pkg::READ_SIZE_4W, 5'h00, wren_r};

    function automatic logic cmd_valid(input logic [2:0] c);
        cmd_valid = (c == eeprom_cmd_pkg::CMD_READ) || (c == eeprom_cmd_pkg::CMD_WRITE) ||
                    (c == eeprom_cmd_pkg::CMD_RELOAD);
    endfunction

    function automatic logic [7:0] reg_read(input logic [15:0] a);
        logic [2:0] idx;
        idx = a[2:0];
        reg_read = 8'h00;
        if (a == eeprom_cmd_pkg::ADDR_ASSIGN) begin
            reg_read = {6'h00, assign_r};
        end else if (a == eeprom_cmd_pkg::ADDR_HOST_ACC) begin
            reg_read = {7'h00, host_acc_r};
        end else if (a == eeprom_cmd_pkg::ADDR_CS_LO) begin
            reg_read = cs_word[7:0];
        end else if (a == eeprom_cmd_pkg::ADDR_CS_HI) begin
            reg_read = cs_word[15:8];
        end else if (a >= eeprom_cmd_pkg::ADDR_WADDR && a <= eeprom_cmd_pkg::ADDR_WADDR_LAST) begin
            reg_read = waddr_r[idx[1:0]*8 +: 8];
        end else if (a >= eeprom_cmd_pkg::ADDR_DATA && a <= eeprom_cmd_pkg::ADDR_DATA_LAST) begin
            reg_read = data_r[idx*8 +: 8];
        end
    endfunction

    // only the owner's accesses steer the command registers
    assign own_acc = owner_r ? h_acc_i : m_acc_i;

    always_comb begin
        logic start;
        logic from_master;
        logic [2:0] scmd;
        logic [2:0] wcmd;
        logic [2:0] bidx;
        assign_nxt = assign_r;
        host_acc_nxt = host_acc_r;
        wren_nxt = wren_r;
        cmd_nxt = cmd_r;
        busy_nxt = busy_r;
        err_we_nxt = err_we_r;
        err_ack_nxt = err_ack_r;
        err_dev_nxt = err_dev_r;
        err_crc_nxt = err_crc_r;
        pend_nxt = pend_r;
        waddr_nxt = waddr_r;
        data_nxt = data_r;
        ldbuf_nxt = ldbuf_r;
        cfg_nxt = cfg_r;
        reload_nxt = reload_r;
        attempt_nxt = attempt_r;
        half_nxt = half_r;
        load_done_nxt = load_done_r;
        op_nxt = op_r;
        op_nxt.req = 1'b0;
        state_nxt = state_r;
        start = 1'b0;
        from_master = 1'b0;
        scmd = cmd_r;
        wcmd = own_acc.wdata[2:0];
        bidx = own_acc.addr[2:0];
        m_rdata_nxt = m_acc_i.rd ? reg_read(m_acc_i.addr) : m_rdata_r;
        h_rdata_nxt = h_acc_i.rd ? reg_read(h_acc_i.addr) : h_rdata_r;

        // ownership registers
        if (h_acc_i.wr && h_acc_i.addr == eeprom_cmd_pkg::ADDR_HOST_ACC &&
            assign_r[eeprom_cmd_pkg::ASSIGN_HOST]) begin
            host_acc_nxt = h_acc_i.wdata[eeprom_cmd_pkg::HOST_ACC_BIT];
        end
        if (m_acc_i.wr && m_acc_i.addr == eeprom_cmd_pkg::ADDR_ASSIGN) begin
            assign_nxt = m_acc_i.wdata[1:0];
            if (m_acc_i.wdata[eeprom_cmd_pkg::ASSIGN_FORCE]) begin
                host_acc_nxt = 1'b0;
            end
        end

        // owner register writes, frozen while a command runs
        if (own_acc.wr && !busy_r) begin
            if (own_acc.addr >= eeprom_cmd_pkg::ADDR_WADDR &&
                own_acc.addr <= eeprom_cmd_pkg::ADDR_WADDR_LAST) begin
                waddr_nxt[bidx[1:0]*8 +: 8] = own_acc.wdata;
            end else if (own_acc.addr >= eeprom_cmd_pkg::ADDR_DATA &&
                         own_acc.addr <= eeprom_cmd_pkg::ADDR_DATA_LAST) begin
                data_nxt[bidx*8 +: 8] = own_acc.wdata;
            end else if (own_acc.addr == eeprom_cmd_pkg::ADDR_CS_LO) begin
                wren_nxt = own_acc.wdata[eeprom_cmd_pkg::CS_WREN];
            end else if (own_acc.addr == eeprom_cmd_pkg::ADDR_CS_HI) begin
                if (wcmd == eeprom_cmd_pkg::CMD_NONE) begin
                    cmd_nxt = eeprom_cmd_pkg::CMD_NONE;
                    pend_nxt = 1'b0;
                    err_we_nxt = 1'b0;
                    err_ack_nxt = 1'b0;
                    err_crc_nxt = 1'b0;
                end else if (!cmd_valid(wcmd)) begin
                    err_ack_nxt = 1'b1;
                    cmd_nxt = eeprom_cmd_pkg::CMD_NONE;
                end else if (owner_r) begin
                    cmd_nxt = wcmd;
                    scmd = wcmd;
                    start = 1'b1;
                end else begin
                    cmd_nxt = wcmd;
                    pend_nxt = 1'b1;
                end
            end
        end

        // frame end: pending master command runs or is dropped
        if (m_eof_i) begin
            wren_nxt = 1'b0;
            if (pend_r) begin
                pend_nxt = 1'b0;
                if (m_frame_ok_i && !owner_r) begin
                    start = 1'b1;
                    from_master = 1'b1;
                end else begin
                    cmd_nxt = eeprom_cmd_pkg::CMD_NONE;
                end
            end
        end

        if (start) begin
            if (from_master && scmd == eeprom_cmd_pkg::CMD_WRITE && !wren_r) begin
                err_we_nxt = 1'b1;
                cmd_nxt = eeprom_cmd_pkg::CMD_NONE;
            end else if (scmd == eeprom_cmd_pkg::CMD_RELOAD) begin
                busy_nxt = 1'b1;
                reload_nxt = 1'b1;
                attempt_nxt = 1'b1;
                half_nxt = 1'b0;
                state_nxt = eeprom_cmd_pkg::ST_LOAD_REQ;
            end else begin
                busy_nxt = 1'b1;
                state_nxt = eeprom_cmd_pkg::ST_CMD_REQ;
            end
        end

        unique case (state_r)
            eeprom_cmd_pkg::ST_IDLE: begin
            end
            eeprom_cmd_pkg::ST_CMD_REQ: begin
                op_nxt.req = 1'b1;
                op_nxt.write = (cmd_r == eeprom_cmd_pkg::CMD_WRITE);
                op_nxt.addr = waddr_r;
                op_nxt.wdata = data_r[15:0];
                state_nxt = eeprom_cmd_pkg::ST_CMD_WAIT;
            end
            eeprom_cmd_pkg::ST_CMD_WAIT: begin
                if (ans_i.done) begin
                    busy_nxt = 1'b0;
                    cmd_nxt = eeprom_cmd_pkg::CMD_NONE;
                    state_nxt = eeprom_cmd_pkg::ST_IDLE;
                    if (ans_i.nack) begin
                        err_ack_nxt = 1'b1;
                    end else if (!op_r.write) begin
                        data_nxt = eeprom_cmd_pkg::READ_SIZE_4W ? ans_i.rdata :
                                   {32'h0000_0000, ans_i.rdata[31:0]};
                    end
                end
            end
            eeprom_cmd_pkg::ST_LOAD_REQ: begin
                op_nxt.req = 1'b1;
                op_nxt.write = 1'b0;
                op_nxt.addr = half_r ? eeprom_cmd_pkg::LOAD_ADDR_HI :
                              eeprom_cmd_pkg::LOAD_ADDR_LO;
                state_nxt = eeprom_cmd_pkg::ST_LOAD_WAIT;
            end
            eeprom_cmd_pkg::ST_LOAD_WAIT: begin
                if (ans_i.done) begin
                    if (!ans_i.nack && !half_r) begin
                        ldbuf_nxt = ans_i.rdata;
                        half_nxt = 1'b1;
                        state_nxt = eeprom_cmd_pkg::ST_LOAD_REQ;
                    end else if (!ans_i.nack && crc_ok) begin
                        // good load: registers take over the new values
                        for (int i = 0; i < 5; i++) begin
                            cfg_nxt[i] = area[i*16 +: 16];
                        end
                        if (reload_r) begin
                            cfg_nxt[4] = cfg_r[4];
                            cfg_nxt[0] = (area[15:0] & ~eeprom_cmd_pkg::LINK_KEEP_MASK) |
                                         (cfg_r[0] & eeprom_cmd_pkg::LINK_KEEP_MASK);
                        end
                        load_done_nxt = 1'b1;
                        err_dev_nxt = 1'b0;
                        busy_nxt = 1'b0;
                        cmd_nxt = eeprom_cmd_pkg::CMD_NONE;
                        reload_nxt = 1'b0;
                        state_nxt = eeprom_cmd_pkg::ST_IDLE;
                    end else if (!attempt_r) begin
                        attempt_nxt = 1'b1;
                        half_nxt = 1'b0;
                        state_nxt = eeprom_cmd_pkg::ST_LOAD_REQ;
                    end else begin
                        // failed: configured registers keep their values
                        if (ans_i.nack) begin
                            err_ack_nxt = 1'b1;
                        end else begin
                            err_crc_nxt = 1'b1;
                        end
                        if (!reload_r) begin
                            err_dev_nxt = 1'b1;
                        end
                        busy_nxt = 1'b0;
                        cmd_nxt = eeprom_cmd_pkg::CMD_NONE;
                        reload_nxt = 1'b0;
                        state_nxt = eeprom_cmd_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = eeprom_cmd_pkg::ST_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
        owner_nxt = assign_nxt[eeprom_cmd_pkg::ASSIGN_HOST] | host_acc_nxt;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            assign_r <= 2'h0;
            host_acc_r <= 1'b0;
            owner_r <= 1'b0;
            wren_r <= 1'b0;
            cmd_r <= eeprom_cmd_pkg::CMD_NONE;
            busy_r <= 1'b1;
            err_we_r <= 1'b0;
            err_ack_r <= 1'b0;
            err_dev_r <= 1'b0;
            err_crc_r <= 1'b0;
            pend_r <= 1'b0;
            waddr_r <= 32'h0000_0000;
            data_r <= 64'h0;
            ldbuf_r <= 64'h0;
            for (int i = 0; i < 5; i++) begin
                cfg_r[i] <= 16'h0000;
            end
            reload_r <= 1'b0;
            attempt_r <= 1'b0;
            half_r <= 1'b0;
            load_done_r <= 1'b0;
            m_rdata_r <= 8'h00;
            h_rdata_r <= 8'h00;
            op_r <= '0;
            state_r <= eeprom_cmd_pkg::ST_LOAD_REQ;
        end else begin
            assign_r <= assign_nxt;
            host_acc_r <= host_acc_nxt;
            owner_r <= owner_nxt;
            wren_r <= wren_nxt;
            cmd_r <= cmd_nxt;
            busy_r <= busy_nxt;
            err_we_r <= err_we_nxt;
            err_ack_r <= err_ack_nxt;
            err_dev_r <= err_dev_nxt;
            err_crc_r <= err_crc_nxt;
            pend_r <= pend_nxt;
            waddr_r <= waddr_nxt;
            data_r <= data_nxt;
            ldbuf_r <= ldbuf_nxt;
            cfg_r <= cfg_nxt;
            reload_r <= reload_nxt;
            attempt_r <= attempt_nxt;
            half_r <= half_nxt;
            load_done_r <= load_done_nxt;
            m_rdata_r <= m_rdata_nxt;
            h_rdata_r <= h_rdata_nxt;
            op_r <= op_nxt;
            state_r <= state_nxt;
        end
    end

    assign m_rdata_o = m_rdata_r;
    assign h_rdata_o = h_rdata_r;
    assign op_o = op_r;
    assign owner_host_o = owner_r;
    assign cfg_pdi_ctrl_o = cfg_r[0];
    assign cfg_pdi_conf_o = cfg_r[1];
    assign cfg_sync_pulse_o = cfg_r[2];
    assign cfg_ext_pdi_o = cfg_r[3];
    assign cfg_alias_o = cfg_r[4];
    // one flop gates all three so they can never disagree
    assign load_done_o = load_done_r;
    assign host_operational_flag_o = load_done_r;
    assign process_mem_en_o = load_done_r;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    sequence seq_cmd_hi_write(logic [2:0] code);
        own_acc.wr && !busy_r && own_acc.addr == eeprom_cmd_pkg::ADDR_CS_HI &&
        own_acc.wdata[2:0] == code;
    endsequence

    sequence seq_host_issue;
        owner_r && state_r == eeprom_cmd_pkg::ST_IDLE && !m_eof_i && own_acc.wr && !busy_r &&
        own_acc.addr == eeprom_cmd_pkg::ADDR_CS_HI && own_acc.wdata[2:0] == eeprom_cmd_pkg::CMD_READ;
    endsequence

    chk_owner_decode: assert property (owner_r == (assign_r[0] | host_acc_r))
        else $error("owner flag disagrees with assignment bits");
    chk_force_release: assert property (m_acc_i.wr &&
        m_acc_i.addr == eeprom_cmd_pkg::ADDR_ASSIGN && m_acc_i.wdata[eeprom_cmd_pkg::ASSIGN_FORCE]
        |=> !host_acc_r)
        else $error("forced release left host access set");
    chk_wren_expire: assert property (m_eof_i |=> !wren_r)
        else $error("write enable survived frame end");
    chk_we_refused: assert property (m_eof_i && m_frame_ok_i && pend_r && !owner_r &&
        cmd_r == eeprom_cmd_pkg::CMD_WRITE && !wren_r |=> err_we_r && !busy_r ##1 !op_r.req)
        else $error("write without enable was not refused");
    chk_master_defer: assert property ((!owner_r && !m_eof_i) ##0
        seq_cmd_hi_write(eeprom_cmd_pkg::CMD_READ) |=> !busy_r && pend_r)
        else $error("master command started before frame end");
    chk_host_immediate: assert property (seq_host_issue |=> busy_r ##1 op_r.req && !op_r.write)
        else $error("host command did not start at once");
    chk_busy_done: assert property (state_r == eeprom_cmd_pkg::ST_CMD_WAIT && ans_i.done
        |=> !busy_r && cmd_r == eeprom_cmd_pkg::CMD_NONE)
        else $error("busy not released on completion");
    chk_clear_errors: assert property (!m_eof_i ##0
        seq_cmd_hi_write(eeprom_cmd_pkg::CMD_NONE) |=> !err_ack_r && !err_we_r && !err_crc_r)
        else $error("command clear left an error flag");
    chk_invalid_cmd: assert property (seq_cmd_hi_write(3'h3) |=> err_ack_r && !busy_r)
        else $error("invalid command not flagged");
    chk_load_gate: assert property ($rose(load_done_r) |->
        $past(state_r) == eeprom_cmd_pkg::ST_LOAD_WAIT && $past(crc_ok) && !$past(ans_i.nack))
        else $error("load done raised without a good load");
    chk_alias_keep: assert property (reload_r |=> $stable(cfg_r[4]))
        else $error("alias changed during reload");
    chk_retry_once: assert property ($rose(err_dev_r) |-> $past(attempt_r) && !busy_r)
        else $error("device info error without a retry");

endmodule

// file: verif/eep_engine_model.sv
// Purpose: serial eeprom engine stand-in answering op requests
// Assumes: one request outstanding, fixed 3 cycle answer
// Notes: rdata toggles outside done so stale data is never mistaken
`timescale 1ns/1ps
module eep_engine_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire eeprom_cmd_pkg::eep_op_t op_i,
    input wire logic nack_i,
    input wire logic [7:0] salt_i,
    output eeprom_cmd_pkg::eep_ans_t ans_o
);
    logic [1:0] cnt_r;
    logic [7:0] a_r;
    function automatic logic [63:0] img(logic [7:0] a, logic [7:0] s);
        for (int k = 0; k < 4; k++) begin
            img[16*k+:16] = (a == 8'h04 && k == 3) ? 16'h88a4 : {s ^ a, 8'(k)};
        end
    endfunction
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 2'h0;
            a_r <= 8'h00;
            ans_o <= '0;
        end else begin
            ans_o.done <= (cnt_r == 2'h1);
            ans_o.nack <= nack_i;
            ans_o.rdata <= (cnt_r == 2'h1) ? img(a_r, salt_i) : ~ans_o.rdata;
            if (op_i.req) begin
                cnt_r <= 2'h3;
                a_r <= op_i.addr[7:0];
            end else if (cnt_r != 2'h0) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule

// file: verif/config_eeprom_command_logic_tb_top.sv
// Purpose: self-checking bench for the eeprom command logic
// Assumes: byte accesses two cycles apart, engine model as far side
// Notes: word 7 always skips the checksum, so crc failure is untested
`timescale 1ns/1ps
module config_eeprom_command_logic_tb_top;
    logic clk_sys_i = 0, nrst_i = 0, m_eof_i = 0, m_frame_ok_i = 0, nack = 0;
    eeprom_cmd_pkg::reg_acc_t m_acc = '0, h_acc = '0;
    eeprom_cmd_pkg::eep_ans_t ans;
    eeprom_cmd_pkg::eep_op_t op;
    logic [7:0] m_rd, h_rd, a8, salt = 8'h00;
    logic [15:0] c_ctrl, c_conf, c_sync, c_ext, c_alias, o_ctrl, o_alias;
    logic owner, done, hop, pme;
    logic [63:0] w;
    int n_mismatch = 0, n_compared = 0, n_req = 0, cyc = 0, r0;
    always #2 clk_sys_i = ~clk_sys_i;
    config_eeprom_command_logic dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .m_acc_i(m_acc), .m_eof_i(m_eof_i), .m_frame_ok_i(m_frame_ok_i), .h_acc_i(h_acc),
        .ans_i(ans), .m_rdata_o(m_rd), .h_rdata_o(h_rd), .op_o(op), .owner_host_o(owner),
        .cfg_pdi_ctrl_o(c_ctrl), .cfg_pdi_conf_o(c_conf), .cfg_sync_pulse_o(c_sync),
        .cfg_ext_pdi_o(c_ext), .cfg_alias_o(c_alias), .load_done_o(done),
        .host_operational_flag_o(hop), .process_mem_en_o(pme));
    eep_engine_model part_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .op_i(op),
        .nack_i(nack), .salt_i(salt), .ans_o(ans));
    function automatic logic [63:0] img(logic [7:0] a, logic [7:0] s);
        for (int k = 0; k < 4; k++) begin
            img[16*k+:16] = (a == 8'h04 && k == 3) ? 16'h88a4 : {s ^ a, 8'(k)};
        end
    endfunction
    task give_verdict;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // cut a hang short well past the few hundred cycles needed
    always @(posedge clk_sys_i) begin
        cyc++;
        if (op.req === 1'b1) n_req++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    task chk(logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task acc(bit h, bit wr, logic [15:0] a, logic [7:0] d);
        eeprom_cmd_pkg::reg_acc_t x;
        x = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(negedge clk_sys_i);
        if (h) h_acc = x;
        else m_acc = x;
        @(negedge clk_sys_i);
        h_acc = '0;
        m_acc = '0;
    endtask
    task idle;
        for (int i = 0; i < 100; i++) begin
            acc(0, 0, 16'h0503, 8'h00);
            if (m_rd[7] === 1'b0) break;
        end
    endtask
    task eof(bit ok);
        @(negedge clk_sys_i);
        m_eof_i = 1;
        m_frame_ok_i = ok;
        @(negedge clk_sys_i);
        m_eof_i = 0;
    endtask
    task mcmd(logic [7:0] c, bit ok);
        acc(0, 1, 16'h0503, c);
        eof(ok);
        idle;
    endtask
    initial begin
        void'($urandom(32'h7b1f9cc5));
        salt = 8'($urandom);
        repeat (8) @(negedge clk_sys_i);
        nrst_i = 1;
        idle;
        w = img(8'h00, salt);
        chk(c_ctrl, w[15:0]);
        chk(c_conf, w[31:16]);
        chk(c_sync, w[47:32]);
        chk(c_ext, w[63:48]);
        w = img(8'h04, salt);
        chk(c_alias, w[15:0]);
        chk({done, hop, pme, owner}, 4'he);
        a8 = 8'($urandom);
        acc(0, 1, 16'h0504, a8);
        r0 = n_req;
        acc(0, 1, 16'h0503, 8'h01);
        chk(16'(n_req), 16'(r0));
        eof(1);
        idle;
        chk(16'(n_req), 16'(r0 + 1));
        w = img(a8, salt);
        for (int k = 0; k < 8; k++) begin
            acc(0, 0, 16'h0508 + 16'(k), 8'h00);
            chk(m_rd, w[8*k+:8]);
        end
        acc(0, 0, 16'h0502, 8'h00);
        chk(m_rd, 8'h40);
        r0 = n_req;
        mcmd(8'h02, 1);
        chk(m_rd, 8'h40);
        mcmd(8'h00, 1);
        chk(m_rd, 8'h00);
        acc(0, 1, 16'h0502, 8'h01);
        mcmd(8'h02, 0);
        chk(16'(n_req), 16'(r0));
        acc(0, 1, 16'h0502, 8'h01);
        mcmd(8'h02, 1);
        chk(16'(n_req), 16'(r0 + 1));
        chk(op.write, 1'b1);
        chk(op.wdata, w[15:0]);
        chk(op.addr[15:0], 16'(a8));
        acc(0, 0, 16'h0502, 8'h00);
        chk(m_rd, 8'h40);
        mcmd(8'h03, 1);
        chk(m_rd & 8'h20, 8'h20);
        mcmd(8'h00, 1);
        nack = 1;
        mcmd(8'h01, 1);
        chk(m_rd, 8'h20);
        nack = 0;
        mcmd(8'h00, 1);
        mcmd(8'h01, 1);
        chk(m_rd, 8'h00);
        acc(0, 1, 16'h0500, 8'h01);
        acc(1, 1, 16'h0501, 8'h01);
        @(negedge clk_sys_i);
        chk(owner, 1'b1);
        r0 = n_req;
        acc(1, 1, 16'h0503, 8'h02);
        idle;
        chk(16'(n_req), 16'(r0 + 1));
        acc(1, 1, 16'h0503, 8'h01);
        idle;
        acc(1, 0, 16'h050e, 8'h00);
        chk(h_rd, w[55:48]);
        chk(16'(n_req), 16'(r0 + 2));
        o_ctrl = c_ctrl;
        o_alias = c_alias;
        salt = ~salt;
        acc(1, 1, 16'h0503, 8'h04);
        idle;
        w = img(8'h00, salt);
        chk(c_conf, w[31:16]);
        chk(c_alias, o_alias);
        chk(c_ctrl, (w[15:0] & ~16'hf200) | (o_ctrl & 16'hf200));
        acc(0, 1, 16'h0504, ~a8);
        acc(0, 0, 16'h0504, 8'h00);
        chk(m_rd, a8);
        acc(0, 1, 16'h0500, 8'h02);
        acc(0, 1, 16'h0500, 8'h00);
        acc(0, 0, 16'h0501, 8'h00);
        chk(m_rd & 8'h01, 8'h00);
        chk(owner, 1'b0);
        nack = 1;
        r0 = n_req;
        nrst_i = 0;
        repeat (8) @(negedge clk_sys_i);
        nrst_i = 1;
        idle;
        chk(16'(n_req), 16'(r0 + 2));
        chk(m_rd, 8'h30);
        chk({done, hop, pme}, 3'h0);
        give_verdict;
    end
endmodule
